// File: adc_hw_trigger_sequencer.sv
// Sequencer for hardware-triggered converter operation
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
module adc_hw_trigger_sequencer #(
   parameter int unsigned CONV_CYCLES = `CONV_CYCLES
) (
   // Clock and reset
   input  wire logic                        clock,
   input  wire logic                        reset,
   // Software control writes
   input  wire logic                        modeWrite,
   input  wire adc_seq_pkg::modeCfg_t       modeData,
   input  wire logic                        powerWrite,
   input  wire logic                        powerData,
   input  wire logic                        runWrite,
   input  wire logic                        runData,
   input  wire logic                        selectWrite,
   input  wire logic [`CHAN_WIDTH-1:0]      selectData,
   // Trigger source and analog result
   input  wire logic                        hwTrigger,
   input  wire logic [`RESULT_WIDTH-1:0]    sarResult,
   // Status and results
   output adc_seq_pkg::modeCfg_t            converterModeReg0_q,
   output logic                             converterPowerEnable_q,
   output logic                             conversionRun_q,
   output logic [`CHAN_WIDTH-1:0]           channelSelectReg_q,
   output adc_seq_pkg::convResult_t         conversionResultReg_q,
   output logic                             conversionDoneIrq_q,
   output adc_seq_pkg::seqState_t           seqState_q,
   output logic [`CHAN_WIDTH-1:0]           activeChannel_q,
   output logic                             analogPowered_q
);
   import adc_seq_pkg::*;

   seqState_t              state_d;
   logic                   run_d;
   logic [1:0]             slot_q;
   logic [1:0]             slot_d;
   logic                   startConv;
   logic                   abortConv;
   logic                   storeResult;
   logic                   timerBusy;
   logic                   timerDone;
   logic                   analog_d;
   logic [`CHAN_WIDTH-1:0] chan_d;

   // Decoded controls
   wire isSoft   = converterModeReg0_q.trig == TRIG_SOFT;
   wire isWait   = converterModeReg0_q.trig == TRIG_WAIT;
   wire isNoWait = converterModeReg0_q.trig == TRIG_NOWAIT;
   wire isScan   = converterModeReg0_q.scan;
   wire isOneSh  = converterModeReg0_q.oneShot;
   wire powerOn  = powerWrite & powerData;
   wire powerOff = powerWrite & ~powerData;
   wire runSet   = runWrite & runData;
   wire runClr   = runWrite & ~runData;
   wire stConv   = seqState_q == ST_CONV;
   wire stArmed  = seqState_q == ST_ARMED;
   wire stIdle   = seqState_q == ST_IDLE;
   wire stStop   = seqState_q == ST_STOP;
   wire trigHw   = hwTrigger & ~isSoft;
   wire lastSlot = ~isScan | (slot_q == `SLOT_LAST);
   wire [`CHAN_WIDTH-1:0] selNext =
      selectWrite ? selectData : channelSelectReg_q;
   wire [`CHAN_WIDTH-1:0] chanFirst = selNext;
   wire [`CHAN_WIDTH-1:0] chanNext =
      selNext + {{(`CHAN_WIDTH-2){1'b0}}, slot_q + 2'h1};
   wire restartReq = trigHw | selectWrite | runSet;

   // Sequencing; power loss outranks every other event
   always_comb begin
      state_d     = seqState_q;
      run_d       = conversionRun_q;
      slot_d      = slot_q;
      chan_d      = activeChannel_q;
      startConv   = 1'b0;
      abortConv   = 1'b0;
      storeResult = 1'b0;
      case (seqState_q)
         ST_STOP: begin
            if (powerOn) begin // RULE21
               state_d = isWait ? ST_ARMED : ST_IDLE; // RULE12
            end
         end
         ST_IDLE: begin
            if (powerOff) begin
               state_d = ST_STOP; // RULE10
            end else if (runSet && isSoft) begin
               state_d   = ST_CONV;
               run_d     = 1'b1;
               slot_d    = `SLOT_FIRST;
               chan_d    = chanFirst;
               startConv = 1'b1;
            end else if (runSet) begin
               state_d = ST_ARMED; // RULE1
               run_d   = ~isWait;
            end
         end
         ST_ARMED: begin
            if (powerOff) begin
               state_d = ST_STOP; // RULE18
               run_d   = 1'b0;
            end else if (runClr && !isWait) begin
               state_d = ST_IDLE;
               run_d   = 1'b0;
            end else if (trigHw && (isWait || conversionRun_q)) begin // RULE11
               state_d   = ST_CONV; // RULE3 RULE13
               run_d     = 1'b1;
               slot_d    = `SLOT_FIRST;
               chan_d    = chanFirst;
               startConv = 1'b1;
            end
         end
         ST_CONV: begin
            storeResult = timerDone & ~powerOff & ~runClr; // RULE4
            if (powerOff) begin
               state_d   = ST_STOP;
               run_d     = 1'b0;
               abortConv = 1'b1;
            end else if (runClr) begin
               state_d   = isWait ? ST_ARMED : ST_IDLE; // RULE9 RULE17
               run_d     = 1'b0;
               abortConv = 1'b1;
            end else if (restartReq) begin
               // RULE6 RULE7 RULE8 RULE19 RULE20
               slot_d    = `SLOT_FIRST;
               chan_d    = chanFirst;
               startConv = 1'b1;
            end else if (timerDone && !lastSlot) begin
               slot_d    = slot_q + 2'h1; // RULE3
               chan_d    = chanNext;
               startConv = 1'b1;
            end else if (timerDone && !isOneSh) begin
               slot_d    = `SLOT_FIRST; // RULE14 RULE16
               chan_d    = chanFirst;
               startConv = 1'b1;
            end else if (timerDone) begin
               state_d = isSoft ? ST_IDLE : ST_ARMED; // RULE5
               run_d   = isNoWait; // RULE15
            end
         end
         default: begin
            state_d = ST_STOP;
            run_d   = 1'b0;
         end
      endcase
   end

   // The wait-mode trigger standby keeps the analog part unpowered; only ST_CONV powers it
   assign analog_d = isWait ? (state_d == ST_CONV) : (state_d != ST_STOP);

   conv_timer #(
      .CYCLES (CONV_CYCLES)
   ) u_timer (
      .clock (clock),
      .reset (reset),
      .start (startConv),
      .abort (abortConv),
      .busy  (timerBusy),
      .done  (timerDone)
   );

   // RULE22
   always_ff @(posedge clock) begin
      if (reset) begin
         converterModeReg0_q <= '{trig: TRIG_SOFT, scan: 1'b0, oneShot: 1'b0};
         converterPowerEnable_q <= 1'b0;
         channelSelectReg_q     <= `CHAN_RESET;
      end else begin
         if (modeWrite) begin
            converterModeReg0_q <= modeData;
         end
         if (powerWrite) begin
            converterPowerEnable_q <= powerData;
         end
         if (selectWrite) begin
            channelSelectReg_q <= selectData;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         seqState_q      <= ST_STOP;
         conversionRun_q <= 1'b0;
         slot_q          <= `SLOT_FIRST;
         activeChannel_q <= `CHAN_RESET;
         analogPowered_q <= 1'b0;
      end else begin
         seqState_q      <= state_d;
         conversionRun_q <= run_d;
         slot_q          <= slot_d;
         activeChannel_q <= chan_d;
         analogPowered_q <= analog_d;
      end
   end

   // Only a finished conversion reaches the result; aborts leave it
   always_ff @(posedge clock) begin
      if (reset) begin
         conversionResultReg_q <= '{value: `RESULT_RESET,
                                    channel: `CHAN_RESET};
         conversionDoneIrq_q   <= 1'b0;
      end else begin
         conversionDoneIrq_q <= storeResult; // RULE4
         if (storeResult) begin
            conversionResultReg_q <= '{value: sarResult,
                                       channel: activeChannel_q}; // RULE23
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   wire quietCtl = ~powerWrite & ~runWrite & ~selectWrite & ~modeWrite;

   sequence convEnd;
      stConv && timerDone && quietCtl && !trigHw;
   endsequence

   sequence freshStart;
      stConv && timerBusy && slot_q == `SLOT_FIRST;
   endsequence

   runArm_nowait_a: assert property ( // RULE1
      stIdle && isNoWait && runSet && !powerWrite && !modeWrite
      |=> (stArmed && conversionRun_q && !timerBusy)
          ##1 (!timerBusy || $past(trigHw)))
      else $error("run set did not arm trigger standby");

   scanOrder_a: assert property ( // RULE3
      stArmed && isNoWait && isScan && conversionRun_q && hwTrigger
      && quietCtl
      |=> freshStart ##0 (activeChannel_q == channelSelectReg_q))
      else $error("scan did not begin at first slot");

   resultIrq_a: assert property ( // RULE4
      stConv && timerDone && !powerOff && !runClr
      |=> conversionDoneIrq_q
          && conversionResultReg_q.value == $past(sarResult)
          && conversionResultReg_q.channel == $past(activeChannel_q))
      else $error("completed conversion not stored");

   scanRearm_a: assert property ( // RULE5
      convEnd ##0 (isNoWait && isScan && isOneSh && slot_q == `SLOT_LAST)
      |=> stArmed && conversionRun_q ##1 conversionDoneIrq_q == 1'b0)
      else $error("one-shot scan did not rearm");

   trigRestart_a: assert property ( // RULE6
      stConv && trigHw && !powerWrite && !runClr
      |=> freshStart ##0 (activeChannel_q == channelSelectReg_q)
          ##1 !timerDone)
      else $error("trigger did not restart conversion");

   selRestart_a: assert property ( // RULE7
      stConv && selectWrite && !powerWrite && !runClr
      |=> freshStart ##0 (activeChannel_q == $past(selectData)))
      else $error("channel write did not restart");

   runRestart_a: assert property ( // RULE8
      stConv && runSet && !powerWrite
      |=> freshStart ##0 conversionRun_q)
      else $error("run rewrite did not restart");

   runClrIdle_a: assert property ( // RULE9
      stConv && !isWait && runClr && !powerWrite
      |=> stIdle && analogPowered_q && !timerBusy
          && !conversionDoneIrq_q)
      else $error("run clear did not abort to standby");

   powerStop_a: assert property ( // RULE10
      stIdle && powerOff |=> stStop && !analogPowered_q)
      else $error("power clear did not stop");

   noRunNoConv_a: assert property ( // RULE11
      (stIdle || stStop) && !isSoft && hwTrigger && !powerOn && !runSet
      |=> !stConv && !timerBusy)
      else $error("trigger started conversion without run");

   waitArm_a: assert property ( // RULE12
      stStop && isWait && powerOn && !modeWrite
      |=> stArmed && !conversionRun_q && !analogPowered_q)
      else $error("wait power-on did not arm");

   waitTrig_a: assert property ( // RULE13
      stArmed && isWait && hwTrigger && !powerOff && !modeWrite
      |=> freshStart ##0 (conversionRun_q && analogPowered_q))
      else $error("wait trigger did not start conversion");

   seqContinue_a: assert property ( // RULE14
      convEnd ##0 (isWait && !isOneSh && lastSlot)
      |=> freshStart ##0 conversionRun_q)
      else $error("sequential conversion did not continue");

   oneShotStop_a: assert property ( // RULE15
      convEnd ##0 (isWait && isOneSh && lastSlot)
      |=> !conversionRun_q && stArmed && !analogPowered_q)
      else $error("wait one-shot did not stop");

   waitRunClr_a: assert property ( // RULE17
      stConv && isWait && runClr && !powerWrite
      |=> stArmed && !conversionRun_q && !analogPowered_q)
      else $error("wait run clear did not return to standby");

   powerOffIdle_a: assert property ( // RULE18
      !converterPowerEnable_q && !powerWrite
      |=> stStop && !timerBusy && !conversionDoneIrq_q)
      else $error("converter active without power enable");

   resultHold_a: assert property ( // RULE23
      !storeResult |=> $stable(conversionResultReg_q))
      else $error("result changed without completion");

   scanStep_a: assert property ( // RULE3
      convEnd ##0 (isScan && slot_q != `SLOT_LAST)
      |=> stConv && slot_q == $past(slot_q) + 2'h1
          && activeChannel_q == $past(activeChannel_q) + 5'h01)
      else $error("scan slots out of order");

   runIgnored_a: assert property ( // RULE21
      stStop && runSet && !powerOn
      |=> stStop && !conversionRun_q && !timerBusy)
      else $error("run set started converter without power");

   scanRepeat_a: assert property ( // RULE16
      convEnd ##0 (isWait && isScan && !isOneSh && slot_q == `SLOT_LAST)
      |=> freshStart ##0 (activeChannel_q == channelSelectReg_q))
      else $error("wait scan did not repeat sequence");

   selTrigSame_a: assert property ( // RULE19
      stConv && !isScan && trigHw && !powerWrite && !runClr && !selectWrite
      |=> freshStart ##0 (activeChannel_q == $past(activeChannel_q)))
      else $error("select trigger did not restart same channel");

   selResume_a: assert property ( // RULE20
      stConv && !isScan && selectWrite && !powerWrite && !runClr
      |=> freshStart ##0 (activeChannel_q == channelSelectReg_q))
      else $error("select write did not resume on new channel");

   modeHold_a: assert property ( // RULE22
      modeWrite |=> converterModeReg0_q == $past(modeData))
      else $error("mode write not held");
endmodule // adc_hw_trigger_sequencer

// File: adc_seq_cfg.svh
// Constants for the hardware-triggered converter sequencer
// Behaviour
// RULE1: No-wait run set only arms trigger standby
// RULE2: Software waits stabilization before setting run
// RULE3: No-wait scan trigger converts four slots in order
// RULE4: Each conversion stores result and raises irq
// RULE5: No-wait scan one-shot rearms, run stays set
// RULE6: Scan trigger mid-conversion restarts from slot zero
// RULE7: Select write aborts, restarts on new channel
// RULE8: Run rewrite aborts and restarts from start
// RULE9: No-wait run clear aborts to powered standby
// RULE10: Power clear in standby enters stop
// RULE11: No-wait triggers ignored while run clear
// RULE12: Wait mode power-on enters trigger standby
// RULE13: Wait trigger starts conversion, sets run
// RULE14: Wait select sequential restarts without trigger
// RULE15: Wait one-shot clears run and stops
// RULE16: Wait scan sequential repeats channel sequence
// RULE17: Wait run clear aborts to trigger standby
// RULE18: Power clear makes triggers ignored
// RULE19: Select trigger mid-conversion restarts same channel
// RULE20: Select mode resumes on newly written channel
// RULE21: Run set ignored while power clear
// RULE22: Mode configuration held and steers everything
// RULE23: Result holds until next completed conversion
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
`define CLK_PERIOD_NS 8
`define STAB_TIME_NS 1000
`define STAB_CYCLES ((`STAB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TIME_NS 2000
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define RESULT_WIDTH 10
`define CHAN_WIDTH 5
`define SLOT_FIRST 2'h0
`define SLOT_LAST 2'h3
`define CHAN_RESET 5'h00
`define RESULT_RESET 10'h000
`endif

// File: adc_seq_pkg.sv
// Types shared by the converter sequencer
`include "adc_seq_cfg.svh"
package adc_seq_pkg;
   typedef enum logic [1:0] {
      TRIG_SOFT   = 2'h0,
      TRIG_NOWAIT = 2'h2,
      TRIG_WAIT   = 2'h3
   } trigMode_t;
   typedef struct packed {
      trigMode_t trig;
      logic      scan;
      logic      oneShot;
   } modeCfg_t;
   typedef enum logic [3:0] {
      ST_STOP  = 4'h1,
      ST_IDLE  = 4'h2,
      ST_ARMED = 4'h4,
      ST_CONV  = 4'h8
   } seqState_t;
   typedef struct packed {
      logic [`RESULT_WIDTH-1:0] value;
      logic [`CHAN_WIDTH-1:0]   channel;
   } convResult_t;
endpackage

// File: conv_timer.sv
// Conversion duration timer with restart and abort
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
module conv_timer #(
   parameter int unsigned CYCLES = `CONV_CYCLES
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // Control
   input  wire logic start,
   input  wire logic abort,
   // Status
   output logic      busy,
   output logic      done
);
   localparam int unsigned CW = $clog2(CYCLES + 1);
   logic [CW-1:0] count_q;
   logic          busy_q;
   logic          done_q;

   // A start while busy reloads the count, dropping the partial work
   always_ff @(posedge clock) begin
      if (reset) begin
         count_q <= '0;
         busy_q  <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (abort) begin
            busy_q <= 1'b0;
         end else if (start) begin
            busy_q  <= 1'b1;
            count_q <= CW'(CYCLES - 1);
         end else if (busy_q) begin
            if (count_q == '0) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end else begin
               count_q <= count_q - 1'b1;
            end
         end
      end
   end

   assign busy = busy_q;
   assign done = done_q;
endmodule // conv_timer

// File: sar_input_model.sv
// Trigger source and analog input model facing the sequencer
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
module sar_input_model (
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     reset,
   // Bench request and converter view
   input  wire logic                     fire,
   input  wire logic                     converting,
   input  wire logic [`CHAN_WIDTH-1:0]   channel,
   // Trigger and analog value
   output logic                          hwTrigger,
   output logic [`RESULT_WIDTH-1:0]      sarResult
);
   localparam logic [4:0] TAG = 5'h15;
   logic [`RESULT_WIDTH-1:0] churn_q;
   always_ff @(posedge clock) begin
      if (reset) churn_q <= 10'h2AA;
      else churn_q <= ~churn_q ^ 10'h001;
   end
   assign hwTrigger = fire;
   // Outside a conversion the value means nothing, so it churns
   assign sarResult = converting ? {TAG, channel} : churn_q;
endmodule // sar_input_model

// File: adc_hw_trigger_sequencer_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
module adc_hw_trigger_sequencer_bench;
   import adc_seq_pkg::*;
   localparam int unsigned N = 4;
   localparam logic [4:0] TAG = 5'h15;
   logic clock, reset, modeWrite, powerWrite, powerData;
   logic runWrite, runData, selectWrite, fire, hwTrigger;
   modeCfg_t modeData, mode;
   logic [4:0] selectData, chanReg, actCh;
   logic [9:0] sarResult;
   convResult_t result;
   seqState_t state;
   logic power, run, irq, analog;
   int nFail = 0;
   int nCompared = 0;
   adc_hw_trigger_sequencer #(.CONV_CYCLES(N)) dut (
      .clock(clock), .reset(reset), .modeWrite(modeWrite),
      .modeData(modeData), .powerWrite(powerWrite),
      .powerData(powerData), .runWrite(runWrite), .runData(runData),
      .selectWrite(selectWrite), .selectData(selectData),
      .hwTrigger(hwTrigger), .sarResult(sarResult),
      .converterModeReg0_q(mode), .converterPowerEnable_q(power),
      .conversionRun_q(run), .channelSelectReg_q(chanReg),
      .conversionResultReg_q(result), .conversionDoneIrq_q(irq),
      .seqState_q(state), .activeChannel_q(actCh),
      .analogPowered_q(analog));
   sar_input_model partner (
      .clock(clock), .reset(reset), .fire(fire),
      .converting(state == ST_CONV), .channel(actCh),
      .hwTrigger(hwTrigger), .sarResult(sarResult));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic summarize;
      $display("compared %0d, mismatches %0d", nCompared, nFail);
      if (nFail == 0 && nCompared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp) begin
         nFail++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask
   // State, run bit and analog power in one compare
   task automatic chkState(input seqState_t s, input logic r,
                           input logic a);
      check(16'({state, run, analog}), 16'({s, r, a}));
   endtask
   task automatic setMode(input trigMode_t t, input logic s,
                          input logic o);
      modeData = '{t, s, o};
      modeWrite = 1'b1;
      step(1);
      modeWrite = 1'b0;
      step(1);
   endtask
   task automatic setPower(input logic v);
      powerData = v;
      powerWrite = 1'b1;
      step(1);
      powerWrite = 1'b0;
      step(1);
   endtask
   task automatic setRun(input logic v);
      runData = v;
      runWrite = 1'b1;
      step(1);
      runWrite = 1'b0;
      step(1);
   endtask
   task automatic setSelect(input logic [4:0] c);
      selectData = c;
      selectWrite = 1'b1;
      step(1);
      selectWrite = 1'b0;
      step(1);
   endtask
   task automatic trigger;
      fire = 1'b1;
      step(1);
      fire = 1'b0;
      step(1);
   endtask
   // Bounded wait for one done pulse, then its stored result
   task automatic waitIrq(input logic [4:0] ch);
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 3 * N + 4) begin
         step(1);
         k++;
      end
      check(16'(irq), 16'h0001);
      check(16'(result), 16'({TAG, ch, ch}));
      step(1);
   endtask
   initial begin
      repeat (5000) @(posedge clock);
      nFail++;
      summarize();
   end
   initial begin
      reset = 1'b1;
      {modeWrite, powerWrite, powerData, runWrite, runData} = 5'h00;
      {selectWrite, fire} = 2'h0;
      modeData = '0;
      selectData = 5'h00;
      repeat (16) @(posedge clock);
      @(negedge clock);
      reset = 1'b0;
      step(1);
      chkState(ST_STOP, 1'b0, 1'b0);
      check(16'(result), 16'h0000);
      setRun(1'b1);
      chkState(ST_STOP, 1'b0, 1'b0);
      $display("test power_off done");
      setMode(TRIG_NOWAIT, 1'b1, 1'b1);
      check(16'(mode), 16'({TRIG_NOWAIT, 2'h3}));
      setSelect(5'h04);
      check(16'(chanReg), 16'h0004);
      setPower(1'b1);
      check(16'(power), 16'h0001);
      step(`STAB_CYCLES);
      trigger();
      step(N + 2);
      chkState(ST_IDLE, 1'b0, 1'b1);
      setRun(1'b1);
      step(N + 2);
      chkState(ST_ARMED, 1'b1, 1'b1);
      trigger();
      for (int i = 0; i < 4; i++) waitIrq(5'h04 + 5'(i));
      step(N + 2);
      chkState(ST_ARMED, 1'b1, 1'b1);
      trigger();
      waitIrq(5'h04);
      trigger();
      waitIrq(5'h04);
      setSelect(5'h08);
      waitIrq(5'h08);
      setRun(1'b1);
      waitIrq(5'h08);
      setRun(1'b0);
      step(N + 2);
      chkState(ST_IDLE, 1'b0, 1'b1);
      check(16'(result), 16'({TAG, 5'h08, 5'h08}));
      setPower(1'b0);
      chkState(ST_STOP, 1'b0, 1'b0);
      $display("test nowait_scan done");
      setMode(TRIG_WAIT, 1'b0, 1'b0);
      setSelect(5'h02);
      setPower(1'b1);
      chkState(ST_ARMED, 1'b0, 1'b0);
      fire = 1'b1;
      step(1);
      fire = 1'b0;
      chkState(ST_CONV, 1'b1, 1'b1);
      check(16'(actCh), 16'h0002);
      waitIrq(5'h02);
      waitIrq(5'h02);
      trigger();
      step(N - 2);
      check(16'(irq), 16'h0000);
      waitIrq(5'h02);
      setSelect(5'h03);
      waitIrq(5'h03);
      setRun(1'b0);
      chkState(ST_ARMED, 1'b0, 1'b0);
      setPower(1'b0);
      trigger();
      step(N + 2);
      chkState(ST_STOP, 1'b0, 1'b0);
      $display("test wait_select done");
      setMode(TRIG_WAIT, 1'b0, 1'b1);
      setPower(1'b1);
      trigger();
      waitIrq(5'h03);
      step(2);
      chkState(ST_ARMED, 1'b0, 1'b0);
      setPower(1'b0);
      $display("test wait_oneshot done");
      setMode(TRIG_WAIT, 1'b1, 1'b0);
      setSelect(5'h1E);
      setPower(1'b1);
      trigger();
      for (int i = 0; i < 5; i++) waitIrq(5'h1E + 5'(i % 4));
      setPower(1'b0);
      chkState(ST_STOP, 1'b0, 1'b0);
      $display("test wait_scan done");
      setMode(TRIG_SOFT, 1'b0, 1'b1);
      setPower(1'b1);
      setRun(1'b1);
      waitIrq(5'h1E);
      step(2);
      chkState(ST_IDLE, 1'b0, 1'b1);
      $display("test soft_oneshot done");
      summarize();
   end
endmodule // adc_hw_trigger_sequencer_bench
